// ==== spw_pkg.sv ====
// Constants and encodings for the shared-period four-channel PWM block
// Notes on behaviour
// - One common base period drives all four outputs; no per-channel period.
// - Period is unsigned 11 bits, 0..2047, in 40 ns ticks.
// - Period write: op 02, group AA, sub 00, flag 00, len 4, id 0035.
// - Period read: op 04, len 2, id 0035; answer op 05, len 4.
// - Duty write: id 0036, len 5, select 0..3 or 4 for all, value.
// - Output active for duty/period of each common period.
// - Duty at or above period keeps the output active all period.
// - Duty of zero keeps the output inactive forever.
// - Duty read: op 04, id 0036, len 3, select; answer len 4 with value.
// - Each packet ends in a sum of all bytes after the flag byte.
// - Accepted requests answer with both status bytes zero.
// - Corrupt requests set status bits; answer shortened to status bytes.
// - Operation byte: 02 write, 03 write answer, 04 read, 05 read answer.
// - Status byte 0: bit 0 checksum, higher bits header, address, execution.
// - Status byte 1 bit 3 flags too little or too much data.
package spw_pkg;
    // Operation, group and identifier codes
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] WRITE_RESPONSE_CODE = 8'h03;
    localparam logic [7:0] OP_READ = 8'h04;
    localparam logic [7:0] READ_RESPONSE_CODE = 8'h05;
    localparam logic [7:0] GROUP_EXT = 8'haa;
    localparam logic [15:0] ID_PERIOD = 16'h0035;
    localparam logic [15:0] ID_DUTY = 16'h0036;
    localparam logic [7:0] SEL_ALL = 8'h04;
    // Expected payload lengths
    localparam logic [15:0] LEN_PER_WR = 16'h0004;
    localparam logic [15:0] LEN_PER_RD = 16'h0002;
    localparam logic [15:0] LEN_DUTY_WR = 16'h0005;
    localparam logic [15:0] LEN_DUTY_RD = 16'h0003;
    localparam logic [7:0] RSP_LEN_SHORT = 8'h02;
    localparam logic [7:0] RSP_LEN_DATA = 8'h04;
    localparam logic [16:0] HDR_BYTES = 17'h00006;
    localparam logic [16:0] SUM_START = 17'h00004;
    // Status bit positions
    localparam int S0_CHECKSUM = 0;
    localparam int S0_OP = 1;
    localparam int S0_GROUP = 2;
    localparam int S0_SUB = 3;
    localparam int S0_FLAG = 4;
    localparam int S0_ADDR = 5;
    localparam int S0_EXEC = 6;
    localparam int S1_LENGTH = 3;
    // Tick timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_NS = 40;
    localparam int TICK_CYC = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] TICK_LAST = 2'(TICK_CYC - 1);
    // Reset values
    localparam logic [10:0] PERIOD_RST = 11'h000;
    localparam logic [10:0] DUTY_RST = 11'h000;
    localparam logic [7:0] CTRL_RST = 8'h01;
    localparam logic [2:0] MASK_RST = 3'h0;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MASK = 8'h08;
    localparam logic [7:0] REG_INFO = 8'h0c;
    // Event bits
    localparam int EV_OK = 0;
    localparam int EV_FAULT = 1;
    localparam int EV_DRAINED = 2;
endpackage : spw_pkg

// ==== spw_spi_byte.sv ====
// Serial byte shifter sampling the link clock with the core clock
`timescale 1ns/1ps
module spw_spi_byte (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    input wire logic spi_cs_b,
    input wire logic [7:0] tx_byte,
    output logic rx_valid,
    output logic [7:0] rx_byte,
    output logic frame_act,
    output logic spi_miso
);
    logic [2:0] sclk_q;
    logic [1:0] mosi_q;
    logic [2:0] cs_q;
    logic [2:0] cnt_q;
    logic [7:0] rx_q;
    logic [7:0] tx_q;
    logic valid_q;
    logic [7:0] byte_q;

    // Edges are taken only from the second and third stages
    wire sclk_rise = sclk_q[1] & ~sclk_q[2];
    wire sclk_fall = ~sclk_q[1] & sclk_q[2];
    wire active = ~cs_q[1];
    wire frame_start = ~cs_q[1] & cs_q[2];
    wire byte_done = active & sclk_rise & (cnt_q == 3'h7);

    // Two-stage synchronisers plus edge history
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sclk_q <= 3'h0;
            mosi_q <= 2'h0;
            cs_q <= 3'h7;
        end else begin
            sclk_q <= {sclk_q[1:0], spi_sclk};
            mosi_q <= {mosi_q[0], spi_mosi};
            cs_q <= {cs_q[1:0], spi_cs_b};
        end
    end

    // Sample on rising, shift out on falling, msb first
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 3'h0;
            rx_q <= 8'h00;
            tx_q <= 8'h00;
        end else if (!active) begin
            cnt_q <= 3'h0;
        end else begin
            if (sclk_rise) begin
                cnt_q <= cnt_q + 3'h1;
                rx_q <= {rx_q[6:0], mosi_q[1]};
            end
            if (frame_start || (sclk_fall && cnt_q == 3'h0)) begin
                tx_q <= tx_byte;
            end else if (sclk_fall) begin
                tx_q <= {tx_q[6:0], 1'b0};
            end
        end
    end

    // Completed byte strobe
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            valid_q <= 1'b0;
            byte_q <= 8'h00;
        end else begin
            valid_q <= byte_done;
            if (byte_done) begin
                byte_q <= {rx_q[6:0], mosi_q[1]};
            end
        end
    end

    assign rx_valid = valid_q;
    assign rx_byte = byte_q;
    assign frame_act = active;
    assign spi_miso = tx_q[7];
endmodule : spw_spi_byte

// ==== spw_pwm_out_d.sv ====
// Four-channel PWM with shared period, packet parser and Wishbone registers
`timescale 1ns/1ps
module spw_pwm_out_d (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    input wire logic spi_cs_b,
    output logic spi_miso,
    output logic resp_pending,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [7:0] wb_adr,
    input wire logic [3:0] wb_sel,
    input wire logic [31:0] wb_dat_w,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    output logic irq,
    output logic pwm_out_a,
    output logic pwm_out_b,
    output logic pwm_out_c,
    output logic pwm_out_d
);
    // Response byte for a given position
    function automatic logic [7:0] rsp_byte(input logic [3:0] i,
        input logic [7:0] op, input logic [7:0] ln, input logic [7:0] s0,
        input logic [7:0] s1, input logic [7:0] d0, input logic [7:0] d1);
        logic [7:0] ck;
        ck = ln + s0 + s1 + ((ln == spw_pkg::RSP_LEN_DATA) ? d0 + d1 : 8'h00);
        case (i)
            4'h0: rsp_byte = op;
            4'h1: rsp_byte = spw_pkg::GROUP_EXT;
            4'h4: rsp_byte = ln;
            4'h6: rsp_byte = s0;
            4'h7: rsp_byte = s1;
            4'h8: rsp_byte = (ln == spw_pkg::RSP_LEN_DATA) ? d0 : ck;
            4'h9: rsp_byte = d1;
            4'ha: rsp_byte = ck;
            default: rsp_byte = 8'h00;
        endcase
    endfunction : rsp_byte

    logic rx_valid;
    logic [7:0] rx_byte;
    logic frame_act;
    logic frame_q;
    logic [16:0] idx_q;
    logic [15:0] len_q;
    logic [7:0] sum_q;
    logic [7:0] op_q, grp_q, sub_q, flg_q;
    logic [7:0] dat_q [0:4];
    logic rsp_ready_q;
    logic [3:0] tx_idx_q;
    logic [7:0] rop_q, rlen_q, s0_q, s1_q, d0_q, d1_q;
    logic [10:0] per_sh_q, per_act_q;
    logic [10:0] duty_sh_q [0:3];
    logic [10:0] duty_act_q [0:3];
    logic [1:0] pre_q;
    logic [10:0] cnt_q;
    logic [3:0] pwm_q;
    logic [7:0] ctrl_q;
    logic [2:0] sts_q, mask_q;
    logic ack_q, irq_q;
    logic [31:0] rdat_q;
    logic [7:0] tx_byte;

    spw_spi_byte u_link (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi),
        .spi_cs_b(spi_cs_b),
        .tx_byte(tx_byte),
        .rx_valid(rx_valid),
        .rx_byte(rx_byte),
        .frame_act(frame_act),
        .spi_miso(spi_miso)
    );

    // Byte routing: a pending response owns the link until drained
    assign tx_byte = rsp_ready_q ? rsp_byte(tx_idx_q, rop_q, rlen_q,
        s0_q, s1_q, d0_q, d1_q) : 8'h00;
    wire req_byte = rx_valid & ~rsp_ready_q;
    wire frame_end = frame_q & ~frame_act;
    wire [16:0] last_idx = {1'b0, len_q} + spw_pkg::HDR_BYTES;
    wire pkt_last = req_byte & (idx_q >= spw_pkg::HDR_BYTES)
        & (idx_q == last_idx);
    wire [16:0] di = idx_q - spw_pkg::HDR_BYTES;
    wire store_dat = (idx_q >= spw_pkg::HDR_BYTES) & (di < 17'd5);
    wire [3:0] tx_last = 4'(rlen_q + 8'h06);
    wire drained = rx_valid & rsp_ready_q & (tx_idx_q == tx_last);

    // Request decode at the checksum byte
    wire [15:0] id = {dat_q[1], dat_q[0]};
    wire is_wr = (op_q == spw_pkg::OP_WRITE);
    wire is_rd = (op_q == spw_pkg::OP_READ);
    wire is_per = (id == spw_pkg::ID_PERIOD);
    wire is_duty = (id == spw_pkg::ID_DUTY);
    wire [15:0] exp_len = is_per ?
        (is_wr ? spw_pkg::LEN_PER_WR : spw_pkg::LEN_PER_RD) :
        (is_wr ? spw_pkg::LEN_DUTY_WR : spw_pkg::LEN_DUTY_RD);
    wire [15:0] wval = is_per ? {dat_q[3], dat_q[2]} : {dat_q[4], dat_q[3]};
    wire [7:0] chan = dat_q[2];
    wire ck_bad = (sum_q != rx_byte);
    wire hdr_bad = ~(is_wr | is_rd) | (grp_q != spw_pkg::GROUP_EXT)
        | (sub_q != 8'h00) | (flg_q != 8'h00);
    wire addr_bad = ~(is_per | is_duty);
    wire len_bad = ~hdr_bad & ~addr_bad & (len_q != exp_len);
    wire pre_ok = ~ck_bad & ~hdr_bad & ~addr_bad & ~len_bad;
    wire exe_bad = pre_ok & ((is_wr & (wval[15:11] != 5'h00))
        | (is_duty & is_wr & (chan > spw_pkg::SEL_ALL))
        | (is_duty & is_rd & (chan >= spw_pkg::SEL_ALL)));
    wire [7:0] s0_d = {1'b0, exe_bad, ~hdr_bad & addr_bad,
        flg_q != 8'h00, sub_q != 8'h00, grp_q != spw_pkg::GROUP_EXT,
        ~(is_wr | is_rd), ck_bad};
    wire [7:0] s1_d = {4'h0, len_bad, 3'h0};
    wire any_err = (s0_d != 8'h00) | (s1_d != 8'h00);
    wire apply_wr = pkt_last & ~any_err & is_wr;
    wire [10:0] rd_val = is_per ? per_sh_q : duty_sh_q[chan[1:0]];

    // Parser state: byte index, header bytes and running sum
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            frame_q <= 1'b0;
            idx_q <= 17'h0;
            len_q <= 16'h0;
            sum_q <= 8'h00;
            {op_q, grp_q, sub_q, flg_q} <= 32'h0;
        end else begin
            frame_q <= frame_act;
            if (frame_end || pkt_last) begin
                idx_q <= 17'h0;
                sum_q <= 8'h00;
            end else if (req_byte) begin
                idx_q <= idx_q + 17'h1;
                if (idx_q >= spw_pkg::SUM_START) begin
                    sum_q <= sum_q + rx_byte;
                end
                case (idx_q)
                    17'h0: op_q <= rx_byte;
                    17'h1: grp_q <= rx_byte;
                    17'h2: sub_q <= rx_byte;
                    17'h3: flg_q <= rx_byte;
                    17'h4: len_q[7:0] <= rx_byte;
                    17'h5: len_q[15:8] <= rx_byte;
                    default: ;
                endcase
            end
        end
    end

    // Payload bytes kept for decode
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 5; i++) dat_q[i] <= 8'h00;
        end else if (req_byte && store_dat && !pkt_last) begin
            dat_q[di[2:0]] <= rx_byte;
        end
    end

    // Response latch and read-out position
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rsp_ready_q <= 1'b0;
            tx_idx_q <= 4'h0;
            {rop_q, rlen_q, s0_q, s1_q, d0_q, d1_q} <= 48'h0;
        end else begin
            if (pkt_last) begin
                rsp_ready_q <= 1'b1;
                rop_q <= is_rd ? spw_pkg::READ_RESPONSE_CODE
                    : spw_pkg::WRITE_RESPONSE_CODE;
                rlen_q <= (is_rd && !any_err) ? spw_pkg::RSP_LEN_DATA
                    : spw_pkg::RSP_LEN_SHORT;
                s0_q <= s0_d;
                s1_q <= s1_d;
                d0_q <= rd_val[7:0];
                d1_q <= {5'h00, rd_val[10:8]};
            end else if (drained) begin
                rsp_ready_q <= 1'b0;
            end
            if (frame_end || drained) begin
                tx_idx_q <= 4'h0;
            end else if (rx_valid && rsp_ready_q) begin
                tx_idx_q <= tx_idx_q + 4'h1;
            end
        end
    end

    // Programmed values; duty select 4 writes every channel
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            per_sh_q <= spw_pkg::PERIOD_RST;
            for (int i = 0; i < 4; i++) duty_sh_q[i] <= spw_pkg::DUTY_RST;
        end else if (apply_wr) begin
            if (is_per) begin
                per_sh_q <= wval[10:0];
            end
            for (int i = 0; i < 4; i++) begin
                if (is_duty && (chan == spw_pkg::SEL_ALL || chan == 8'(i))) begin
                    duty_sh_q[i] <= wval[10:0];
                end
            end
        end
    end

    // Tick prescaler and shared period counter
    wire run = ctrl_q[0];
    wire tick = run & (pre_q == spw_pkg::TICK_LAST);
    wire per_end = ({1'b0, cnt_q} + 12'h001) >= {1'b0, per_act_q};
    wire bound = ~run | (tick & per_end);
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pre_q <= 2'h0;
            cnt_q <= 11'h000;
        end else begin
            pre_q <= (tick || !run) ? 2'h0 : pre_q + 2'h1;
            if (bound) begin
                cnt_q <= 11'h000;
            end else if (tick) begin
                cnt_q <= cnt_q + 11'h001;
            end
        end
    end

    // Active values reload only at the boundary
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            per_act_q <= spw_pkg::PERIOD_RST;
            for (int i = 0; i < 4; i++) duty_act_q[i] <= spw_pkg::DUTY_RST;
        end else if (bound) begin
            per_act_q <= per_sh_q;
            for (int i = 0; i < 4; i++) duty_act_q[i] <= duty_sh_q[i];
        end
    end

    // Output compare per channel
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pwm_q <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                pwm_q[i] <= run && (duty_act_q[i] != 11'h000)
                    && (duty_act_q[i] >= per_act_q
                    || cnt_q < duty_act_q[i]);
            end
        end
    end

    // Wishbone decode
    wire wb_req = wb_cyc & wb_stb & ~ack_q;
    wire wr_ctrl = wb_req & wb_we & wb_sel[0] & (wb_adr == spw_pkg::REG_CTRL);
    wire wr_mask = wb_req & wb_we & wb_sel[0] & (wb_adr == spw_pkg::REG_MASK);
    wire rd_sts = wb_req & ~wb_we & (wb_adr == spw_pkg::REG_STATUS);
    wire [2:0] ev = {drained, pkt_last & any_err, pkt_last & ~any_err};
    wire [2:0] sts_d = (sts_q & ~{3{rd_sts}}) | ev;
    wire [31:0] rd_mux = (wb_adr == spw_pkg::REG_CTRL) ? {24'h0, ctrl_q} :
        (wb_adr == spw_pkg::REG_STATUS) ? {29'h0, sts_q} :
        (wb_adr == spw_pkg::REG_MASK) ? {29'h0, mask_q} :
        (wb_adr == spw_pkg::REG_INFO) ? {s1_q, s0_q, 5'h00, per_act_q} :
        32'h0;

    // Register file, sticky status with set over clear
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= spw_pkg::CTRL_RST;
            mask_q <= spw_pkg::MASK_RST;
            sts_q <= 3'h0;
            ack_q <= 1'b0;
            rdat_q <= 32'h0;
            irq_q <= 1'b0;
        end else begin
            if (wr_ctrl) ctrl_q <= wb_dat_w[7:0];
            if (wr_mask) mask_q <= wb_dat_w[2:0];
            sts_q <= sts_d;
            ack_q <= wb_req;
            if (wb_req && !wb_we) rdat_q <= rd_mux;
            irq_q <= (sts_d & mask_q) != 3'h0;
        end
    end

    assign wb_ack = ack_q;
    assign wb_dat_r = rdat_q;
    assign irq = irq_q;
    assign resp_pending = rsp_ready_q;
    assign pwm_out_a = pwm_q[0];
    assign pwm_out_b = pwm_q[1];
    assign pwm_out_c = pwm_q[2];
    assign pwm_out_d = pwm_q[3];

    // Checks on timing and decode
    tick_spacing_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        tick && run |=> !tick [*3] ##1 (tick || !run))
        else $error("tick spacing wrong");
    period_load_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        bound |=> per_act_q == $past(per_sh_q))
        else $error("period not loaded at boundary");
    hold_mid_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !bound |=> $stable(per_act_q) && $stable(duty_act_q[2]))
        else $error("values changed mid period");
    zero_duty_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        duty_act_q[0] == 11'h000 |=> !pwm_q[0])
        else $error("zero duty output active");
    full_duty_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        run && duty_act_q[2] != 11'h000 && duty_act_q[2] >= per_act_q
        |=> pwm_q[2])
        else $error("full duty output dropped");
    duty_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        duty_act_q[3] < per_act_q && cnt_q >= duty_act_q[3]
        |=> !pwm_q[3])
        else $error("output active past duty");
    ok_status_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        pkt_last && !any_err |=> rsp_ready_q && s0_q == 8'h00
        && s1_q == 8'h00)
        else $error("accepted request status not zero");
    sum_fault_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        pkt_last && ck_bad |=> s0_q[spw_pkg::S0_CHECKSUM]
        && rlen_q == spw_pkg::RSP_LEN_SHORT)
        else $error("checksum fault not flagged");
    len_fault_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        pkt_last && len_bad |=> s1_q[spw_pkg::S1_LENGTH])
        else $error("length fault not flagged");
    wb_ack_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wb_req |=> wb_ack ##1 !wb_ack)
        else $error("bus answer timing wrong");
    per_write_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
        apply_wr && is_per);
    duty_read_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
        pkt_last && is_rd && is_duty && !any_err);
    drained_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
        drained);
endmodule : spw_pwm_out_d

// ==== spw_host_model.sv ====
// Serial host model: mode 0 master, link clock idle low outside frames
`timescale 1ns/1ps
module spw_host_model (
    input wire logic ref_clk,
    output logic spi_sclk,
    output logic spi_mosi,
    output logic spi_cs_b,
    input wire logic spi_miso
);
    // Idle: deselected, clock low
    initial {spi_sclk, spi_mosi, spi_cs_b} = 3'b011;
    // One frame: eight 80 ns pulses, 160 ns apart, per byte, msb first
    task automatic frame(input logic [7:0] tx[$], output logic [7:0] rx[$]);
        logic [7:0] b;
        rx = {};
        spi_cs_b <= 1'b0;
        repeat (8) @(posedge ref_clk);
        foreach (tx[k]) begin
            for (int i = 7; i >= 0; i--) begin
                spi_mosi <= tx[k][i];
                repeat (8) @(posedge ref_clk);
                b[i] = spi_miso;
                spi_sclk <= 1'b1;
                repeat (8) @(posedge ref_clk);
                spi_sclk <= 1'b0;
            end
            rx.push_back(b);
        end
        repeat (8) @(posedge ref_clk);
        spi_cs_b <= 1'b1;
        spi_mosi <= ~spi_mosi; // Released line keeps no stale level
        repeat (8) @(posedge ref_clk);
    endtask : frame
endmodule : spw_host_model

// ==== tb_top.sv ====
// Self-checking bench for the shared-period four-channel PWM block
`timescale 1ns/1ps
module tb_top;
    typedef logic [7:0] spw_q_t[$];
    logic ref_clk, rst_b, spi_sclk, spi_mosi, spi_cs_b, spi_miso, irq;
    logic resp_pending, wb_cyc, wb_stb, wb_we, wb_ack;
    logic pwm_out_a, pwm_out_b, pwm_out_c, pwm_out_d;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat_w, wb_dat_r;
    int errors, tests_run, cycles;
    // Block under test and the serial host facing it
    spw_pwm_out_d i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi), .spi_cs_b(spi_cs_b), .spi_miso(spi_miso),
        .resp_pending(resp_pending), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .irq(irq),
        .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
        .pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b),
        .pwm_out_c(pwm_out_c), .pwm_out_d(pwm_out_d));
    spw_host_model i_host (.ref_clk(ref_clk), .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi), .spi_cs_b(spi_cs_b), .spi_miso(spi_miso));
    // Core clock and hang ceiling
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            errors++;
            stop_test();
        end
    end
    // Count a comparison, report a mismatch
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask : chk
    // Classic bus cycle; a read is compared with e
    task automatic wb(input logic we, input logic [7:0] a,
        input logic [31:0] d, input logic [31:0] e);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_sel <= 4'h1;
        wb_adr <= a;
        wb_dat_w <= d;
        @(posedge ref_clk);
        while (wb_ack !== 1'b1) @(posedge ref_clk);
        if (!we) chk(wb_dat_r, e);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge ref_clk);
    endtask : wb
    // Packet: header, length, data, sum from length onward
    function automatic spw_q_t mk(input logic [7:0] op, input spw_q_t d,
        input logic [7:0] bad);
        spw_q_t p;
        logic [7:0] s;
        p = {op, 8'haa, 8'h00, 8'h00, 8'(d.size()), 8'h00};
        s = 8'(d.size()) + bad;
        foreach (d[i]) begin
            p.push_back(d[i]);
            s += d[i];
        end
        p.push_back(s);
        return p;
    endfunction : mk
    // Short answer with given status bytes
    function automatic spw_q_t st(input logic [7:0] op,
        input logic [7:0] s0, input logic [7:0] s1);
        return mk(op, {s0, s1}, 8'h00);
    endfunction : st
    // Request in one frame, answer clocked out in the next
    task automatic cmd(input spw_q_t q, input spw_q_t e);
        spw_q_t rx;
        spw_q_t z;
        i_host.frame(q, rx);
        while (resp_pending !== 1'b1) @(posedge ref_clk);
        foreach (e[i]) z.push_back(8'h00);
        i_host.frame(z, rx);
        foreach (e[i]) chk(rx[i], e[i]);
        chk(resp_pending, 0);
    endtask : cmd
    // Reset levels, register defaults, unmapped address
    task automatic t_reset;
        chk({irq, resp_pending, pwm_out_a, pwm_out_b, pwm_out_c,
            pwm_out_d}, 0);
        wb(1'b0, 8'h00, 0, 32'h1);
        wb(1'b1, 8'h40, 32'hff, 0);
        wb(1'b0, 8'h40, 0, 32'h0);
        wb(1'b1, 8'h08, 32'hff, 0);
        wb(1'b0, 8'h08, 0, 32'h7);
        $display("test reset done");
    endtask : t_reset
    // Shared period, single and all-channel duty, 0 and 100 percent
    task automatic t_pwm;
        int c[4];
        logic [7:0] v[3] = '{8'h02, 8'h00, 8'h09};
        cmd(mk(8'h02, {8'h35, 8'h00, 8'h08, 8'h00}, 0), st(3, 0, 0));
        cmd(mk(8'h02, {8'h36, 8'h00, 8'h04, 8'h05, 8'h00}, 0),
            st(3, 0, 0));
        for (int s = 0; s < 3; s++) begin
            cmd(mk(8'h02, {8'h36, 8'h00, 8'(s), v[s], 8'h00}, 0),
                st(3, 0, 0));
        end
        repeat (64) @(posedge ref_clk);
        c = '{0, 0, 0, 0};
        repeat (320) begin
            @(posedge ref_clk);
            c[0] += int'(pwm_out_a === 1'b1);
            c[1] += int'(pwm_out_b === 1'b1);
            c[2] += int'(pwm_out_c === 1'b1);
            c[3] += int'(pwm_out_d === 1'b1);
        end
        chk(c[0], 80);
        chk(c[1], 0);
        chk(c[2], 320);
        chk(c[3], 200);
        wb(1'b1, 8'h00, 32'h0, 0);
        repeat (8) @(posedge ref_clk);
        chk(pwm_out_c, 0);
        wb(1'b1, 8'h00, 32'h1, 0);
        chk(pwm_out_c, 1);
        cmd(mk(8'h04, {8'h36, 8'h00, 8'h03}, 0),
            mk(8'h05, {8'h00, 8'h00, 8'h05, 8'h00}, 0));
        $display("test pwm done");
    endtask : t_pwm
    // Corrupt requests give status bits and short answers
    task automatic t_fault;
        cmd(mk(8'h02, {8'h35, 8'h00, 8'h08, 8'h00}, 1), st(3, 1, 0));
        cmd(mk(8'h02, {8'h35, 8'h00, 8'h08, 8'h00, 8'h00}, 0),
            st(3, 0, 8'h08));
        cmd(mk(8'h02, {8'h35, 8'h00, 8'h00, 8'h08}, 0),
            st(3, 8'h40, 0));
        cmd(mk(8'h07, {8'h35, 8'h00}, 0), st(3, 8'h02, 0));
        cmd(mk(8'h04, {8'h36, 8'h00, 8'h04}, 0), st(5, 8'h40, 0));
        $display("test fault done");
    endtask : t_fault
    // Sticky events, mask, read-clear and level interrupt
    task automatic t_irq;
        wb(1'b1, 8'h08, 32'h1, 0);
        wb(1'b0, 8'h04, 0, 32'h7);
        cmd(mk(8'h04, {8'h35, 8'h00}, 0),
            mk(8'h05, {8'h00, 8'h00, 8'h08, 8'h00}, 0));
        chk(irq, 1);
        wb(1'b0, 8'h04, 0, 32'h5);
        wb(1'b0, 8'h0c, 0, 32'h8);
        chk(irq, 0);
        cmd(mk(8'h02, {8'h35, 8'h00, 8'h08, 8'h00}, 1), st(3, 1, 0));
        chk(irq, 0);
        wb(1'b0, 8'h0c, 0, 32'h0001_0008);
        wb(1'b0, 8'h04, 0, 32'h6);
        $display("test irq done");
    endtask : t_irq
    // Print counts and verdict, then end the run
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test
    // Reset, then the scenarios in order
    initial begin
        rst_b = 1'b0;
        {wb_cyc, wb_stb, wb_we} = 3'h0;
        wb_adr = 8'h00;
        wb_sel = 4'h1;
        wb_dat_w = 32'h0;
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge ref_clk);
        t_reset();
        t_pwm();
        t_fault();
        t_irq();
        stop_test();
    end
endmodule : tb_top
